// File: spi_master_slave_port.sv
// Serial port core that runs as bus master or slave, with a Wishbone register slave.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        sck_i,
  input  wire logic        mosi_i,
  input  wire logic        miso_i,
  input  wire logic        ss_n_i,
  output pins_out_t        pins_o,
  output logic             transfer_irq,
  output logic             fault_irq
);

  // Shifter states, Gray coded along idle, run, finish.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_RUN    = 2'b01,
    ST_FINISH = 2'b11
  } state_t;

  // Divisor half period lookup, used by the rate generator.
  function automatic logic [6:0] half_period(input logic [2:0] code);
    case (code)
      3'h0:    half_period = 7'h01;
      3'h1:    half_period = 7'h02;
      3'h2:    half_period = 7'h04;
      3'h3:    half_period = 7'h08;
      3'h4:    half_period = 7'h10;
      3'h5:    half_period = 7'h20;
      3'h6:    half_period = 7'h40;
      default: half_period = 7'h40; // The invalid code runs at the slowest rate.
    endcase
  endfunction : half_period

  logic [1:0]  rst_sync;          // Reset release pipeline.
  logic        rst_n;             // Synchronised active low reset.
  logic [7:0]  control_reg;       // Control register.
  logic        done_reg;          // Transfer done flag.
  logic        collision_reg;     // Write collision flag.
  logic        fault_reg;         // Mode fault flag.
  logic [7:0]  rx_buffer_reg;     // Received byte buffer.
  logic [7:0]  shift_reg;         // Shift register.
  logic [3:0]  bit_cnt_reg;       // Bits left in the exchange, counted per bit.
  logic [6:0]  div_cnt_reg;       // Rate generator counter.
  logic        sck_reg;           // Master clock level.
  logic        second_half_reg;   // High when next master edge is the second one of a bit.
  logic        in_bit_reg;        // Sampled input bit, waiting for the shift edge.
  logic        status_seen_reg;   // Status read with a flag set, arming the clearing sequence.
  logic [2:0]  sample_pipe_reg;   // Master sample strobes, delayed to match the synchroniser.
  logic [7:0]  rx_shift_reg;      // Bits received in master mode.
  state_t      state_reg;         // Shifter state.
  logic [2:0]  sck_sync, ss_sync, mosi_sync, miso_sync; // Pin synchronisers.
  logic        sck_q, ss_q;       // Agreed pin levels.
  logic        sck_prev;          // Previous agreed slave clock.
  ctrl_t       ctrl;              // Control fields.
  logic        bus_req, bus_wr, wr_ctrl, wr_data, rd_status, rd_data;
  logic        busy, slave_sel, s_edge, s_lead, s_trail, m_tick, m_sample, fault_evt, done_evt;

  assign rst_n = rst_sync[1];

  // Reset is applied at once and released two clocks later.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign ctrl.enable   = control_reg[ENABLE_BIT];
  assign ctrl.ss_dis   = control_reg[SS_DIS_BIT];
  assign ctrl.master   = control_reg[MASTER_BIT];
  assign ctrl.polarity = control_reg[POLARITY_BIT];
  assign ctrl.phase    = control_reg[PHASE_BIT];
  assign ctrl.rate     = {control_reg[RATE_HIGH_BIT], control_reg[RATE_MID_BIT],
                          control_reg[RATE_LOW_BIT]};

  // Pins cross through three flops; a clock or select level counts when the last two agree.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_sync  <= 3'h0;
      ss_sync   <= 3'h7;
      mosi_sync <= 3'h0;
      miso_sync <= 3'h0;
      sck_q     <= 1'b0;
      ss_q      <= 1'b1;
    end else if (clk_en) begin
      sck_sync  <= {sck_sync[1:0], sck_i};
      ss_sync   <= {ss_sync[1:0], ss_n_i};
      mosi_sync <= {mosi_sync[1:0], mosi_i};
      miso_sync <= {miso_sync[1:0], miso_i};
      if (sck_sync[2] == sck_sync[1]) begin
        sck_q <= sck_sync[2];
      end
      if (ss_sync[2] == ss_sync[1]) begin
        ss_q <= ss_sync[2];
      end
    end
  end

  // Bus decode: one-cycle ack, only when ack is low so each request is taken once.
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];
  assign wr_ctrl   = bus_wr && (wb_adr_i == CONTROL_OFFSET);
  assign wr_data   = bus_wr && (wb_adr_i == DATA_OFFSET);
  assign rd_status = bus_req && !wb_we_i && (wb_adr_i == STATUS_OFFSET);
  assign rd_data   = bus_req && !wb_we_i && (wb_adr_i == DATA_OFFSET);
  assign busy      = (state_reg != ST_IDLE);

  // Ack and read data; unmapped addresses answer zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          CONTROL_OFFSET: wb_dat_o <= {24'h00_0000, control_reg};
          STATUS_OFFSET:  wb_dat_o <= {24'h00_0000, done_reg, collision_reg, 1'b0,
                                       fault_reg, 4'h0};
          DATA_OFFSET:    wb_dat_o <= {24'h00_0000, rx_buffer_reg};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Slave is selected by a low select, or always when phase is one and select is off.
  assign slave_sel = !ctrl.master && ctrl.enable &&
                     (!ss_q || (ctrl.ss_dis && ctrl.phase)); // [RQ10]

  // Mode fault: a master sees select low, unless select is disabled.
  assign fault_evt = ctrl.enable && ctrl.master && !ctrl.ss_dis && !ss_q; // [RQ9] [RQ17]

  // Control register; a fault clears enable and master, and a write in the same cycle is dropped.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= CONTROL_RESET; // [RQ21]
    end else if (clk_en) begin
      if (fault_evt) begin
        control_reg[ENABLE_BIT] <= 1'b0; // [RQ17]
        control_reg[MASTER_BIT] <= 1'b0; // [RQ17]
      end else if (wr_ctrl) begin
        control_reg <= wb_dat_i[7:0];
      end
    end
  end

  // A status read with a flag set arms the clearing sequence.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (rd_status) begin
        status_seen_reg <= done_reg || collision_reg || fault_reg;
      end else if (wr_ctrl || rd_data || wr_data) begin
        status_seen_reg <= 1'b0;
      end
    end
  end

  // Flags: hardware set wins over the clearing sequence in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg      <= 1'b0; // [RQ21]
      collision_reg <= 1'b0;
      fault_reg     <= 1'b0;
    end else if (clk_en) begin
      if (done_evt) begin
        done_reg <= 1'b1; // [RQ18]
      end else if (status_seen_reg && (rd_data || wr_data)) begin
        done_reg <= 1'b0;
      end
      if (wr_data && busy) begin
        collision_reg <= 1'b1; // [RQ19]
      end else if (status_seen_reg && (rd_data || wr_data)) begin
        collision_reg <= 1'b0;
      end
      // Only the status-then-control sequence clears the fault, not ss_dis itself.
      if (fault_evt) begin
        fault_reg <= 1'b1; // [RQ17]
      end else if (status_seen_reg && wr_ctrl) begin
        fault_reg <= 1'b0; // [RQ11]
      end
    end
  end

  // Slave clock edges: leading leaves idle, trailing returns to it.
  assign s_edge  = (sck_q != sck_prev);
  assign s_lead  = s_edge && (sck_q != ctrl.polarity);
  assign s_trail = s_edge && (sck_q == ctrl.polarity);
  assign m_tick  = (div_cnt_reg == 7'h01);

  // Master sampling edge; MISO is taken three clocks later, behind its synchroniser.
  assign m_sample = (state_reg == ST_RUN) && ctrl.master && ctrl.enable && m_tick &&
                    (second_half_reg == ctrl.phase); // [RQ3]

  // Previous slave clock level.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
    end else if (clk_en) begin
      sck_prev <= sck_q;
    end
  end

  // Rate generator: half a serial bit takes half the divisor in core clocks.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 7'h01;
    end else if (clk_en) begin
      if (state_reg != ST_RUN || m_tick) begin
        div_cnt_reg <= half_period(ctrl.rate); // [RQ13] [RQ14]
      end else begin
        div_cnt_reg <= div_cnt_reg - 7'h01;
      end
    end
  end

  // Delayed MISO capture: the third flop read three clocks after the sampling edge holds
  // the line level at that edge, so even the fastest rate receives the right bits.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_pipe_reg <= 3'h0;
      rx_shift_reg    <= 8'h00;
    end else if (clk_en) begin
      sample_pipe_reg <= {sample_pipe_reg[1:0], m_sample};
      if (sample_pipe_reg[2]) begin
        rx_shift_reg <= {rx_shift_reg[6:0], miso_sync[2]}; // [RQ1] [RQ3]
      end
    end
  end

  // Shifter: one sampling edge and one shifting edge per bit, full duplex.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_IDLE;
      shift_reg       <= 8'h00;
      bit_cnt_reg     <= 4'h0;
      sck_reg         <= 1'b0;
      second_half_reg <= 1'b0;
      in_bit_reg      <= 1'b0;
      rx_buffer_reg   <= 8'h00;
      done_evt        <= 1'b0;
    end else if (clk_en) begin
      done_evt <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          sck_reg         <= ctrl.polarity; // [RQ16]
          second_half_reg <= 1'b0;
          bit_cnt_reg     <= BITS_PER_BYTE;
          if (wr_data) begin
            shift_reg <= wb_dat_i[7:0]; // Load also in slave mode for the next exchange.
          end
          if (wr_data && ctrl.enable && ctrl.master) begin
            state_reg <= ST_RUN; // [RQ20]
          end else if (slave_sel && (ctrl.phase ? s_lead : (s_lead || s_trail))) begin
            // Phase one starts on the first edge; phase zero data already stands.
            state_reg <= ST_RUN;
            if (!ctrl.phase) begin
              in_bit_reg <= mosi_sync[2];
              bit_cnt_reg <= BITS_PER_BYTE - 4'h1;
              if (s_trail) begin
                shift_reg <= {shift_reg[6:0], mosi_sync[2]};
              end
            end
          end
        end
        ST_RUN: begin
          if (ctrl.master) begin
            if (!ctrl.enable) begin
              state_reg <= ST_IDLE;
            end else if (m_tick) begin
              sck_reg         <= !sck_reg; // [RQ4]
              second_half_reg <= !second_half_reg;
              // Sample on the leading edge for phase zero, trailing for phase one.
              if (second_half_reg == ctrl.phase) begin
                in_bit_reg <= miso_sync[2]; // [RQ3]
              end else if (!(bit_cnt_reg == BITS_PER_BYTE && ctrl.phase)) begin
                shift_reg   <= {shift_reg[6:0], in_bit_reg}; // [RQ1] [RQ2]
              end
              if (second_half_reg) begin
                bit_cnt_reg <= bit_cnt_reg - 4'h1;
                if (bit_cnt_reg == 4'h1) begin
                  state_reg <= ST_FINISH;
                end
              end
            end
          end else if (!slave_sel) begin
            state_reg <= ST_IDLE; // [RQ7]
          end else if (ctrl.phase ? s_trail : s_lead) begin
            in_bit_reg <= mosi_sync[2]; // [RQ2]
            if (ctrl.phase && bit_cnt_reg == 4'h1) begin
              shift_reg <= {shift_reg[6:0], mosi_sync[2]};
              state_reg <= ST_FINISH;
            end
            bit_cnt_reg <= bit_cnt_reg - 4'h1;
          end else if (ctrl.phase ? s_lead : s_trail) begin
            shift_reg <= {shift_reg[6:0], in_bit_reg}; // [RQ1]
            if (!ctrl.phase && bit_cnt_reg == 4'h0) begin
              state_reg <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          // A master waits until the delayed MISO samples have all landed.
          if (!(ctrl.master && (|sample_pipe_reg))) begin
            rx_buffer_reg <= ctrl.master ? rx_shift_reg : shift_reg; // [RQ1]
            done_evt      <= 1'b1; // [RQ18]
            state_reg     <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive: master drives clock and MOSI, selected slave drives MISO.
  always_comb begin
    pins_o.sck_o   = sck_reg;
    pins_o.sck_oe  = ctrl.enable && ctrl.master; // [RQ4]
    pins_o.mosi_o  = shift_reg[7];
    pins_o.mosi_oe = ctrl.enable && ctrl.master; // [RQ2]
    pins_o.miso_o  = shift_reg[7];
    pins_o.miso_oe = slave_sel; // [RQ6] [RQ7] [RQ3]
  end

  assign transfer_irq = done_reg; // [RQ18]
  assign fault_irq    = fault_reg && !ctrl.ss_dis; // [RQ17]

  // Assertions guarding the main behaviour.
  a_reset_idle_clock: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ21]
    (state_reg == ST_IDLE && clk_en && $past(clk_en)) |-> (sck_reg == $past(ctrl.polarity)))
    else $error("Clock not at idle level while idle.");
  a_miso_release: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ6]
    (!ctrl.master && ss_q && !(ctrl.ss_dis && ctrl.phase)) |-> !pins_o.miso_oe)
    else $error("MISO driven while not selected.");
  a_no_fault_ss_pin_disable: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ9]
    (ctrl.master && ctrl.ss_dis && !fault_reg && clk_en) |=> !fault_reg)
    else $error("Fault set with select disabled.");
  a_fault_clears_en: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ17]
    (fault_evt && clk_en) |=> (fault_reg && !ctrl.enable && !ctrl.master))
    else $error("Fault did not disable the port.");
  a_collision_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ19]
    (wr_data && state_reg == ST_RUN && clk_en) |=> (collision_reg && busy))
    else $error("Collision not flagged or transfer stopped.");
  a_start_on_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ20]
    (wr_data && !busy && ctrl.enable && ctrl.master && clk_en) |=> (state_reg == ST_RUN))
    else $error("Master write did not start exchange.");
  a_done_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ18]
    (done_evt && clk_en) |=> done_reg)
    else $error("Transfer done flag not set.");
  a_ss_pin_disable_keeps_fault: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ11]
    (fault_reg && wr_ctrl && !status_seen_reg && clk_en) |=> fault_reg)
    else $error("Fault cleared without the sequence.");
  a_rate_divisor: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ14]
    (state_reg == ST_RUN && m_tick && clk_en) |=> (div_cnt_reg == half_period(ctrl.rate)))
    else $error("Rate generator reloaded wrong value.");

endmodule : spi_master_slave_port

// File: spi_port_pkg.sv
// Package with register map, field positions, reset values and carriers of the serial port.
// What this block does
// RQ1: Shift out and in together each exchange.
// RQ2: MOSI master to slave, MSB first.
// RQ3: MISO slave to master, same bit order.
// RQ4: Master makes clock, eight cycles per byte.
// RQ5: Selecting party holds select low whole message.
// RQ6: Unselected slave releases MISO to high impedance.
// RQ7: Unselected slave leaves bus activity alone.
// RQ8: Master selects only one slave at once.
// RQ9: Master with select disabled never sets fault.
// RQ10: Slave, phase one, select disabled: always selected.
// RQ11: Clearing select disable keeps fault flag.
// RQ12: Do not disable select with phase zero.
// RQ13: Master clock rate from three select bits.
// RQ14: Codes zero to six divide by 2..128.
// RQ15: Configure master before enabling, master first.
// RQ16: Polarity sets idle level, phase sets sample edge.
// RQ17: Mode fault sets flag, clears enable, master.
// RQ18: Completed byte sets transfer done flag.
// RQ19: Write during transfer flags collision, continues.
// RQ20: Idle master write loads and starts exchange.
// RQ21: After reset disabled, flags clear, clock idle.
package spi_port_pkg;

  // Byte offsets of the registers on the bus.
  localparam logic [3:0] CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET  = 4'h4;
  localparam logic [3:0] DATA_OFFSET    = 4'h8;

  // Control register field positions.
  localparam int RATE_HIGH_BIT  = 7;
  localparam int ENABLE_BIT     = 6;
  localparam int SS_DIS_BIT     = 5;
  localparam int MASTER_BIT     = 4;
  localparam int POLARITY_BIT   = 3;
  localparam int PHASE_BIT      = 2;
  localparam int RATE_MID_BIT   = 1;
  localparam int RATE_LOW_BIT   = 0;

  // Status register field positions.
  localparam int DONE_BIT       = 7;
  localparam int COLLISION_BIT  = 6;
  localparam int FAULT_BIT      = 4;

  // Reset value of the control register.
  localparam logic [7:0] CONTROL_RESET = 8'h14;

  // Bits in one exchange.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Control fields gathered for the shifter.
  typedef struct packed {
    logic       enable;
    logic       ss_dis;
    logic       master;
    logic       polarity;
    logic       phase;
    logic [2:0] rate;
  } ctrl_t;

  // Serial pins as seen by the core.
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } pins_out_t;

endpackage : spi_port_pkg

// File: spi_slave_partner.sv
// Behavioural serial slave that answers the port while the port runs as master.
`timescale 1ns/1ps
module spi_slave_partner (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] sh   = 8'h00; // Outgoing shifter.
  logic       dbit = 1'b0;  // Bit now presented on the data line.

  // Load the reply when selected, so that phase zero sees the first bit before any edge.
  always @(negedge ss_n) begin
    sh = tx_byte;
    dbit = tx_byte[7];
    rx_byte = 8'h00;
  end

  // Sample on one clock edge and move the reply on the other one, as the phase asks.
  always @(sck) begin
    if (!ss_n) begin
      if ((sck != clock_polarity) != clock_phase) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else if (clock_phase) begin
        dbit = sh[7];
        sh = {sh[6:0], 1'b0};
      end else begin
        sh = {sh[6:0], 1'b0};
        dbit = sh[7];
      end
    end
  end

  // A released line shows the inverse of its last bit, so stale data never reads as good.
  assign miso = ss_n ? ~dbit : dbit;

endmodule : spi_slave_partner

// File: spi_master_slave_port_tb_top.sv
// Self-checking bench for the serial port in master and slave mode.
`timescale 1ns/1ps
module spi_master_slave_port_tb_top
  import spi_port_pkg::*;
;
  logic        sys_clk = 1'b0;           // Core clock, 50 MHz.
  logic        rstn    = 1'b0;           // Active-low reset.
  logic        clk_en  = 1'b1;           // Clock enable, dropped once mid-transfer.
  logic [3:0]  adr     = 4'h0;           // Bus address.
  logic [31:0] dat     = 32'h0000_0000;  // Bus write data.
  logic [3:0]  sel     = 4'h0;           // Bus byte enables.
  logic        we      = 1'b0;           // Bus direction.
  logic        cyc     = 1'b0;           // Bus cycle.
  logic        stb     = 1'b0;           // Bus strobe.
  logic        sck_i   = 1'b0;           // Clock driven in slave mode.
  logic        mosi_i  = 1'b0;           // Data driven in slave mode.
  logic        ss_n_i  = 1'b1;           // Select of the port itself.
  logic [31:0] wb_dat_o;                 // Bus read data.
  logic        wb_ack_o;                 // Bus acknowledge.
  pins_out_t   pins_o;                   // Serial pin outputs.
  logic        transfer_irq;             // Done request.
  logic        fault_irq;                // Fault request.
  logic        p_ss_n  = 1'b1;           // Partner select, a general purpose line.
  logic        p_clock_polarity  = 1'b0;           // Partner polarity.
  logic        p_clock_phase  = 1'b0;           // Partner phase.
  logic [7:0]  p_tx    = 8'h00;          // Partner reply byte.
  logic [7:0]  p_rx;                     // Byte the partner received.
  logic        p_miso;                   // Partner data line.
  logic [31:0] seed    = 32'h0001_676C;  // Random state.
  logic [7:0]  rxbuf   = 8'h00;          // Model of the receive buffer.
  int          mismatches = 0;           // Failed comparisons.
  int          compares   = 0;           // All comparisons.
  int          cyc_cnt = 0;              // Core cycle count.
  int          last_t  = 0;              // Cycle of the last serial clock toggle.
  int          gap     = 0;              // Cycles between the last two toggles.
  int          toggles = 0;              // Serial clock toggles seen.
  logic [7:0]  sv [6] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h40, 8'h64}; // Slave cases.

  spi_master_slave_port uut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wb_ack_o), .sck_i(sck_i), .mosi_i(mosi_i),
    .miso_i(p_miso), .ss_n_i(ss_n_i), .pins_o(pins_o), .transfer_irq(transfer_irq),
    .fault_irq(fault_irq));

  spi_slave_partner partner (.sck(pins_o.sck_o), .mosi(pins_o.mosi_o), .ss_n(p_ss_n),
    .clock_polarity(p_clock_polarity), .clock_phase(p_clock_phase), .tx_byte(p_tx), .miso(p_miso), .rx_byte(p_rx));

  // Free-running clock and cycle counter.
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc_cnt <= cyc_cnt + 1;

  // Measure the serial clock so that rate and edge count can be judged.
  always @(pins_o.sck_o) begin
    gap = cyc_cnt - last_t;
    last_t = cyc_cnt;
    toggles++;
  end

  // Xorshift source for data bytes.
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // Compare and report.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic bus cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    sel <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  // Read a register; the upper bits must read as zero.
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, {24'h00_0000, e});
  endtask : rdchk

  task automatic clks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : clks

  // One master exchange with the partner, optionally with a colliding data write.
  task automatic mxfer(input logic [7:0] c, input logic coll);
    logic [7:0] tx;
    logic [7:0] ptx;
    int         dv;
    int         n;
    tx = rnd();
    ptx = rnd();
    dv = 2 << {c[7], c[1:0]};
    n = 0;
    wr(CONTROL_OFFSET, c);
    wr(CONTROL_OFFSET, c | 8'h40);
    p_clock_polarity <= c[3];
    p_clock_phase <= c[2];
    p_tx <= ptx;
    p_ss_n <= 1'b0;
    clks(2);
    chk(pins_o.sck_o, c[3]);
    chk({pins_o.sck_oe, pins_o.mosi_oe}, 2'b11);
    toggles = 0;
    wr(DATA_OFFSET, tx);
    if (coll) begin
      clks(20);
      wr(DATA_OFFSET, 8'h5A);
      rdchk(STATUS_OFFSET, 8'h40);
      // Freeze the core for a while: the serial clock must stand still meanwhile.
      clk_en <= 1'b0;
      clks(1);
      n = toggles;
      clks(200);
      chk(toggles, n);
      clk_en <= 1'b1;
      n = 0;
    end
    while (transfer_irq !== 1'b1 && n < 3000) begin
      clks(1);
      n++;
    end
    if (n >= 3000) mismatches++;
    chk(toggles, 16);
    chk(gap, dv / 2);
    chk(p_rx, tx);
    p_ss_n <= 1'b1;
    rdchk(STATUS_OFFSET, coll ? 8'hC0 : 8'h80);
    rdchk(DATA_OFFSET, ptx);
    rxbuf = ptx;
    rdchk(STATUS_OFFSET, 8'h00);
  endtask : mxfer

  // One slave exchange with the bench acting as master; ssl is the select level.
  task automatic sx(input logic [7:0] c, input logic ssl);
    logic [7:0] tx;
    logic [7:0] mtx;
    logic       s;
    tx = rnd();
    mtx = rnd();
    s = !ssl || (c[5] && c[2]);
    wr(CONTROL_OFFSET, c & 8'hBF);
    sck_i <= c[3];
    wr(CONTROL_OFFSET, c);
    wr(DATA_OFFSET, tx);
    ss_n_i <= ssl;
    clks(10);
    for (int b = 7; b >= 0; b--) begin
      mosi_i <= mtx[b];
      sck_i <= c[2] ? ~c[3] : c[3];
      clks(10);
      chk(pins_o.miso_oe, s);
      if (s) chk(pins_o.miso_o, tx[b]);
      sck_i <= c[2] ? c[3] : ~c[3];
      clks(10);
    end
    sck_i <= c[3];
    clks(10);
    ss_n_i <= 1'b1;
    clks(10);
    if (s) rxbuf = mtx;
    rdchk(STATUS_OFFSET, s ? 8'h80 : 8'h00);
    rdchk(DATA_OFFSET, rxbuf);
  endtask : sx

  // Print the counts and the verdict, then stop.
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Main sequence: reset, registers, master, slave, fault handling.
  initial begin
    clks(5);
    rstn <= 1'b1;
    clks(3);
    chk({pins_o.sck_o, pins_o.sck_oe, pins_o.mosi_oe, pins_o.miso_oe}, 0);
    chk({transfer_irq, fault_irq}, 0);
    rdchk(CONTROL_OFFSET, CONTROL_RESET);
    rdchk(STATUS_OFFSET, 8'h00);
    wr(4'hC, 8'hFF);
    rdchk(4'hC, 8'h00);
    rdchk(CONTROL_OFFSET, CONTROL_RESET);
    $display("test reset done");
    for (int i = 0; i < 7; i++) mxfer({i[2], 3'b001, i[0], i[1], i[1:0]}, 1'b0);
    mxfer(8'h92, 1'b1);
    $display("test master done");
    for (int k = 0; k < 6; k++) sx(sv[k], k >= 4);
    $display("test slave done");
    wr(CONTROL_OFFSET, 8'h10);
    wr(CONTROL_OFFSET, 8'h50);
    ss_n_i <= 1'b0;
    clks(10);
    chk(fault_irq, 1'b1);
    rdchk(CONTROL_OFFSET, 8'h00);
    wr(CONTROL_OFFSET, 8'h20);
    clks(2);
    chk(fault_irq, 1'b0);
    wr(CONTROL_OFFSET, 8'h00);
    rdchk(STATUS_OFFSET, 8'h10);
    wr(CONTROL_OFFSET, 8'h70);
    clks(10);
    rdchk(STATUS_OFFSET, 8'h00);
    rdchk(CONTROL_OFFSET, 8'h70);
    ss_n_i <= 1'b1;
    $display("test fault done");
    summarize();
  end

  // Watchdog well beyond the few thousand cycles the tests need.
  initial begin
    clks(20000);
    mismatches++;
    summarize();
  end

endmodule : spi_master_slave_port_tb_top
